// ---- hw/srp_packetizer.sv ----
// Serial receive packetizer with gap timer, terminators and modem control
//
// Added by the designer: the strobed register port and the register addresses.
`timescale 1ns/1ps
// Function
// - Zero length threshold: no length limit
// - Release when count reaches length threshold
// - Primary terminator byte releases the buffer
// - Both terminators: need both bytes received
// - Release at 1 KB even with terminators
// - Terminator option ignored without primary terminator
// - Plain option: release at terminator
// - Plus-one option: release one byte later
// - Plus-two option: release two bytes later
// - Strip option: drop terminator bytes
// - Zero gap timeout disables gap release
// - Release when idle gap exceeds timeout
// - 1 KB buffer released when full
// - Link-down low forces RTS and DTR low
// - Link-down high leaves RTS and DTR alone
// - Network data to serial in order
module srp_packetizer
    import srp_pkg::*;
#(
    parameter int unsigned CYC_MS = CYC_PER_MS  // Clock cycles per gap unit
)
(
    input  wire logic        clock,      // System clock
    input  wire logic        rst,        // Synchronous reset, high
    input  wire logic [7:0]  addr,       // Register byte address
    input  wire logic [31:0] wdata,      // Register write data
    input  wire logic        wr_en,      // Register write strobe
    input  wire logic        rd_en,      // Register read strobe
    output logic      [31:0] rdata,      // Read data, cycle after strobe
    input  wire logic        rx_valid,   // Serial byte present
    input  wire logic [7:0]  rx_data,    // Serial byte
    output logic             rx_ready,   // Packetizer takes byte
    output logic             tx_valid,   // Block byte to network
    output logic      [7:0]  tx_data,    // Block byte
    output logic             tx_last,    // Final byte of block
    input  wire logic        tx_ready,   // Network takes byte
    input  wire logic        net_valid,  // Network byte present
    input  wire logic [7:0]  net_data,   // Network byte
    output logic             net_ready,  // Forwarder takes byte
    output logic             ser_valid,  // Byte toward serial port
    output logic      [7:0]  ser_data,   // Byte toward serial port
    input  wire logic        ser_ready,  // Serial side takes byte
    input  wire logic        link_up,    // Network connection alive
    output logic             rts,        // Modem control RTS
    output logic             dtr         // Modem control DTR
);

    // All control state of the block
    typedef struct packed {
        srp_state_t        st;
        logic [CNT_W-1:0]  cnt;
        logic [CNT_W-1:0]  len;
        logic [CNT_W-1:0]  rd;
        logic [7:0]        txd;
        logic [1:0]        extra;
        logic              prev_d1;
        logic [PRE_W-1:0]  pre;
        logic [MS_W-1:0]   ms;
        logic [CNT_W-1:0]  flen;
        logic [7:0]        d1;
        logic [7:0]        d2;
        logic              d1_en;
        logic              d2_en;
        srp_dmode_t        dmode;
        logic [15:0]       gap;
        logic              rts_cfg;
        logic              dtr_cfg;
        logic              lnk_low;
        logic [31:0]       rdata;
        logic              ser_v;
        logic [7:0]        ser_d;
    } srp_state_s_t;

    srp_state_s_t s;
    srp_state_s_t next_s;

    // Receive buffer storage
    logic [7:0] mem [0:BUF_DEPTH-1];

    logic       acc;
    logic       hit;
    logic       trig;
    logic       strip;
    logic [1:0] dlen;

    // Count of terminator bytes in use
    function automatic logic [1:0] term_len(input logic d2e);
        term_len = d2e ? 2'h2 : 2'h1;
    endfunction

    // Byte of the buffer at a count position
    function automatic logic [BUF_AW-1:0] slot(input logic [CNT_W-1:0] c);
        slot = c[BUF_AW-1:0];
    endfunction

    assign acc = rx_valid && (s.st == SRP_FILL);

    // Terminator match; secondary alone is never consulted
    always_comb
    begin
        hit = 1'b0;
        if (s.d1_en && (s.extra == 2'h0))
        begin
            if (s.d2_en)
                hit = s.prev_d1 && (rx_data == s.d2);
            else
                hit = (rx_data == s.d1);
        end
    end

    // Release decision for an accepted byte
    always_comb
    begin
        trig  = 1'b0;
        strip = 1'b0;
        dlen  = term_len(s.d2_en);
        if (acc)
        begin
            // Waiting bytes after a terminator
            if (s.extra == 2'h1)
                trig = 1'b1;
            // Terminator itself
            if (hit && (s.dmode == SRP_DM_PLAIN))
                trig = 1'b1;
            if (hit && (s.dmode == SRP_DM_STRIP))
            begin
                trig  = 1'b1;
                strip = 1'b1;
            end
            // Length threshold, zero means no limit
            if ((s.flen != RST_LEN) && (s.cnt + ONE >= s.flen))
                trig = 1'b1;
            // Buffer full regardless of terminators
            if (s.cnt + ONE == FULL_CNT)
                trig = 1'b1;
        end
    end

    // Buffer write of accepted serial bytes
    always_ff @(posedge clock)
    begin
        if (acc)
            mem[slot(s.cnt)] <= rx_data;
    end

    // Next-state logic
    always_comb
    begin
        next_s       = s;
        next_s.rdata = 32'h0000_0000;

        // Register writes
        if (wr_en)
        begin
            case (addr)
                OFS_LEN:
                    next_s.flen = wdata[CNT_W-1:0];
                OFS_DELIM:
                begin
                    next_s.d1    = wdata[F_D1 +: 8];
                    next_s.d2    = wdata[F_D2 +: 8];
                    next_s.d1_en = wdata[F_D1_EN];
                    next_s.d2_en = wdata[F_D2_EN];
                    next_s.dmode = srp_dmode_t'(wdata[F_MODE +: 2]);
                end
                OFS_GAP:
                    next_s.gap = wdata[15:0];
                OFS_MODEM:
                begin
                    next_s.rts_cfg = wdata[F_RTS];
                    next_s.dtr_cfg = wdata[F_DTR];
                    next_s.lnk_low = wdata[F_LNK_LOW];
                end
                default:
                    next_s.flen = s.flen;
            endcase
        end

        // Register reads, unmapped answers zero
        if (rd_en)
        begin
            case (addr)
                OFS_LEN:
                    next_s.rdata[CNT_W-1:0] = s.flen;
                OFS_DELIM:
                begin
                    next_s.rdata[F_D1 +: 8]  = s.d1;
                    next_s.rdata[F_D2 +: 8]  = s.d2;
                    next_s.rdata[F_D1_EN]    = s.d1_en;
                    next_s.rdata[F_D2_EN]    = s.d2_en;
                    next_s.rdata[F_MODE +: 2] = s.dmode;
                end
                OFS_GAP:
                    next_s.rdata[15:0] = s.gap;
                OFS_MODEM:
                begin
                    next_s.rdata[F_RTS]     = s.rts_cfg;
                    next_s.rdata[F_DTR]     = s.dtr_cfg;
                    next_s.rdata[F_LNK_LOW] = s.lnk_low;
                end
                OFS_STATUS:
                begin
                    next_s.rdata[CNT_W-1:0]    = s.cnt;
                    next_s.rdata[F_STATE +: 2] = s.st;
                    next_s.rdata[F_LINK_UP]    = link_up;
                end
                default:
                    next_s.rdata = 32'h0000_0000;
            endcase
        end

        // Gap timer runs except while sending, cleared by each accepted byte; saturates
        if (s.pre == PRE_W'(CYC_MS - 1))
        begin
            next_s.pre = '0;
            if (s.ms != {MS_W{1'b1}})
                next_s.ms = s.ms + MS_W'(1);
        end
        else
        begin
            next_s.pre = s.pre + PRE_W'(1);
        end

        case (s.st)
            SRP_FILL:
            begin
                if (acc)
                begin
                    next_s.cnt     = s.cnt + ONE;
                    next_s.prev_d1 = (rx_data == s.d1);
                    next_s.pre     = '0;
                    next_s.ms      = '0;
                    if (s.extra != 2'h0)
                        next_s.extra = s.extra - 2'h1;
                    else if (hit && (s.dmode == SRP_DM_PLUS1))
                        next_s.extra = 2'h1;
                    else if (hit && (s.dmode == SRP_DM_PLUS2))
                        next_s.extra = 2'h2;
                    if (trig)
                    begin
                        // Terminators sit at the tail when stripping
                        next_s.len = strip ? (s.cnt + ONE - CNT_W'(dlen))
                                           : (s.cnt + ONE);
                        next_s.rd  = '0;
                        next_s.st  = SRP_LOAD;
                    end
                end
                else if ((s.gap != RST_GAP) && (s.cnt != '0)
                         && (s.ms > MS_W'(s.gap)))
                begin
                    next_s.len = s.cnt;
                    next_s.rd  = '0;
                    next_s.st  = SRP_LOAD;
                end
            end
            SRP_LOAD:
            begin
                // Empty block after stripping sends nothing
                if (s.len == '0)
                begin
                    next_s.st = SRP_FILL;
                end
                else
                begin
                    next_s.txd = mem[slot(s.rd)];
                    next_s.rd  = s.rd + ONE;
                    next_s.st  = SRP_SEND;
                end
                next_s.cnt     = '0;
                next_s.extra   = 2'h0;
                next_s.prev_d1 = 1'b0;
            end
            SRP_SEND:
            begin
                next_s.ms  = '0;
                next_s.pre = '0;
                if (tx_ready)
                begin
                    if (s.rd == s.len)
                    begin
                        next_s.st = SRP_FILL;
                    end
                    else
                    begin
                        next_s.txd = mem[slot(s.rd)];
                        next_s.rd  = s.rd + ONE;
                    end
                end
            end
            default:
                next_s.st = SRP_FILL;
        endcase

        // One-stage forwarder keeps network bytes in order
        if (ser_valid && ser_ready)
            next_s.ser_v = 1'b0;
        if (net_valid && net_ready)
        begin
            next_s.ser_v = 1'b1;
            next_s.ser_d = net_data;
        end
    end

    // State register
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            s         <= '0;
            s.st      <= SRP_FILL;
            s.flen    <= RST_LEN;
            s.gap     <= RST_GAP;
            s.dmode   <= SRP_DM_PLAIN;
            s.rts_cfg <= RST_RTS;
            s.dtr_cfg <= RST_DTR;
            s.lnk_low <= RST_LNK_LOW;
        end
        else
        begin
            s <= next_s;
        end
    end

    // Handshakes and outputs
    assign rx_ready  = (s.st == SRP_FILL);
    assign tx_valid  = (s.st == SRP_SEND);
    assign tx_data   = s.txd;
    assign tx_last   = (s.st == SRP_SEND) && (s.rd == s.len);
    assign net_ready = !s.ser_v || ser_ready;
    assign ser_valid = s.ser_v;
    assign ser_data  = s.ser_d;
    assign rdata     = s.rdata;

    // Link loss pulls modem lines low only when so configured
    assign rts = s.rts_cfg && !(s.lnk_low && !link_up);
    assign dtr = s.dtr_cfg && !(s.lnk_low && !link_up);

endmodule // srp_packetizer

// ---- hw/srp_pkg.sv ----
// Package of constants and types for the serial receive packetizer
package srp_pkg;

    // Buffer geometry
    localparam int unsigned BUF_DEPTH   = 1024;
    localparam int unsigned BUF_AW      = 10;
    localparam int unsigned CNT_W       = 11;

    // Clock and gap timer base
    localparam int unsigned CLK_PERIOD_NS = 40;
    localparam int unsigned GAP_UNIT_NS   = 1000000;
    localparam int unsigned CYC_PER_MS    = GAP_UNIT_NS / CLK_PERIOD_NS;
    localparam int unsigned PRE_W         = 16;
    localparam int unsigned MS_W          = 17;

    // Register offsets
    localparam logic [7:0] OFS_LEN    = 8'h00;
    localparam logic [7:0] OFS_DELIM  = 8'h04;
    localparam logic [7:0] OFS_GAP    = 8'h08;
    localparam logic [7:0] OFS_MODEM  = 8'h0c;
    localparam logic [7:0] OFS_STATUS = 8'h10;

    // Field positions
    localparam int unsigned F_D1      = 0;
    localparam int unsigned F_D2      = 8;
    localparam int unsigned F_D1_EN   = 16;
    localparam int unsigned F_D2_EN   = 17;
    localparam int unsigned F_MODE    = 18;
    localparam int unsigned F_RTS     = 0;
    localparam int unsigned F_DTR     = 1;
    localparam int unsigned F_LNK_LOW = 2;
    localparam int unsigned F_STATE   = 16;
    localparam int unsigned F_LINK_UP = 20;

    // Reset values
    localparam logic [10:0] RST_LEN     = 11'h000;
    localparam logic [15:0] RST_GAP     = 16'h0000;
    localparam logic        RST_RTS     = 1'b1;
    localparam logic        RST_DTR     = 1'b1;
    localparam logic        RST_LNK_LOW = 1'b0;

    // Size constants
    localparam logic [10:0] FULL_CNT = 11'h400;
    localparam logic [10:0] ONE      = 11'h001;
    localparam logic [10:0] TWO      = 11'h002;

    // Terminator handling options
    typedef enum logic [1:0] {
        SRP_DM_PLAIN = 2'h0,
        SRP_DM_PLUS1 = 2'h1,
        SRP_DM_PLUS2 = 2'h2,
        SRP_DM_STRIP = 2'h3
    } srp_dmode_t;

    // Packetizer states, gray along fill, load, send
    typedef enum logic [1:0] {
        SRP_FILL = 2'b00,
        SRP_LOAD = 2'b01,
        SRP_SEND = 2'b11
    } srp_state_t;

endpackage : srp_pkg

// ---- dv/srp_packetizer_chk.sv ----
// Port-level assertions for the serial receive packetizer
`timescale 1ns/1ps
module srp_packetizer_chk
(
    input  wire logic        clock,      // System clock
    input  wire logic        rst,        // Synchronous reset, high
    input  wire logic        rd_en,      // Register read strobe
    input  wire logic [31:0] rdata,      // Register read data
    input  wire logic        rx_ready,   // Packetizer takes byte
    input  wire logic        tx_valid,   // Block byte present
    input  wire logic [7:0]  tx_data,    // Block byte
    input  wire logic        tx_last,    // Final byte of block
    input  wire logic        tx_ready,   // Network takes byte
    input  wire logic        net_valid,  // Network byte present
    input  wire logic [7:0]  net_data,   // Network byte
    input  wire logic        net_ready,  // Forwarder takes byte
    input  wire logic        ser_valid,  // Byte toward serial
    input  wire logic [7:0]  ser_data,   // Byte toward serial
    input  wire logic        ser_ready   // Serial side takes byte
);
    logic [10:0] blk_cnt;  // Bytes of the current block already taken

    // Count taken bytes; a block that outgrows the buffer shows here
    always_ff @(posedge clock)
    begin
        if (rst || (tx_valid && tx_ready && tx_last))
            blk_cnt <= 11'h000;
        else if (tx_valid && tx_ready)
            blk_cnt <= blk_cnt + 11'h001;
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    // Steps of a block hand-over
    sequence s_last_taken;
        tx_valid && tx_ready && tx_last;
    endsequence
    sequence s_resume;
        !tx_valid ##[0:1] rx_ready;
    endsequence

    a_last_resume: assert property (s_last_taken |=> s_resume)
        else $error("filling did not resume after block");
    a_block_cap: assert property (tx_valid |-> blk_cnt < 11'h400)
        else $error("block longer than buffer");
    a_rx_held: assert property (tx_valid |-> !rx_ready)
        else $error("bytes taken while sending");
    a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last))
        else $error("block byte changed before taken");
    a_read_idle: assert property (!rd_en |=> rdata == 32'h0)
        else $error("read data outside read cycle");
    a_fwd_order: assert property (net_valid && net_ready |=> ser_valid && ser_data == $past(net_data))
        else $error("forwarded byte lost or changed");
    a_fwd_hold: assert property (ser_valid && !ser_ready |=> ser_valid && $stable(ser_data))
        else $error("serial byte dropped before taken");
    a_fwd_full: assert property (ser_valid && !ser_ready |-> !net_ready)
        else $error("forwarder would overwrite byte");
    a_reset_idle: assert property (disable iff (1'b0) rst |=> !tx_valid && !ser_valid && rx_ready && rdata == 32'h0)
        else $error("outputs not idle after reset");
endmodule // srp_packetizer_chk

bind srp_packetizer srp_packetizer_chk chk (.clock(clock), .rst(rst), .rd_en(rd_en), .rdata(rdata),
    .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready),
    .net_valid(net_valid), .net_data(net_data), .net_ready(net_ready), .ser_valid(ser_valid),
    .ser_data(ser_data), .ser_ready(ser_ready));

// ---- dv/srp_serial_dev.sv ----
// Model of the attached serial device
`timescale 1ns/1ps
module srp_serial_dev
(
    input  wire logic       clock,      // System clock
    output logic            rx_valid,   // Byte offered to packetizer
    output logic      [7:0] rx_data,    // Offered byte
    input  wire logic       rx_ready,   // Packetizer takes byte
    input  wire logic       ser_valid,  // Byte from forwarder
    input  wire logic [7:0] ser_data,   // Byte from forwarder
    output logic            ser_ready   // Device takes byte
);
    logic [7:0] tx_q[$];   // Bytes waiting to be sent
    logic [7:0] got_q[$];  // Bytes received from the forwarder
    int         tick = 0;  // Drives the slow drain pattern

    initial
    begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
        ser_ready = 1'b0;
    end

    // Queued bytes go back to back, so a block never splits on a gap
    always @(posedge clock)
    begin
        if (rx_valid && rx_ready)
            void'(tx_q.pop_front());
        if (tx_q.size() > 0)
        begin
            rx_valid <= 1'b1;
            rx_data <= tx_q[0];
        end
        else
        begin
            rx_valid <= 1'b0;
            rx_data <= ~rx_data;  // Idle line keeps moving, no stale byte
        end
        // Slow drain: takes only one cycle in three
        tick <= tick + 1;
        ser_ready <= (tick % 3) == 0;
        if (ser_valid && ser_ready)
            got_q.push_back(ser_data);
    end
endmodule // srp_serial_dev

// ---- dv/test_srp_packetizer.sv ----
// Self-checking bench for the serial receive packetizer
`timescale 1ns/1ps
module test_srp_packetizer;
    import srp_pkg::*;
    localparam int unsigned CMS = 10;  // Short gap unit keeps runs brief
    logic        clock = 1'b0, rst = 1'b1, wr_en = 1'b0, rd_en = 1'b0, tx_ready = 1'b0;
    logic        net_valid = 1'b0, link_up = 1'b1;
    logic        rx_valid, rx_ready, tx_valid, tx_last, net_ready, ser_valid, ser_ready, rts, dtr;
    logic [7:0]  addr = 8'h00, net_data = 8'h00, rx_data, tx_data, ser_data;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic [7:0]  got_q[$], exp_q[$], src_q[$];
    logic [7:0]  seq5[5] = '{8'h61, 8'h62, 8'h0d, 8'h78, 8'h79};
    int          first[5] = '{3, 4, 5, 2, 5};
    int          len_q[$], elen_q[$], failures = 0, checks_done = 0, cyc = 0, run = 0, m;

    srp_packetizer #(.CYC_MS(CMS)) DUT (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
        .rd_en(rd_en), .rdata(rdata), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready), .net_valid(net_valid),
        .net_data(net_data), .net_ready(net_ready), .ser_valid(ser_valid), .ser_data(ser_data),
        .ser_ready(ser_ready), .link_up(link_up), .rts(rts), .dtr(dtr));
    srp_serial_dev dev (.clock(clock), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
        .ser_valid(ser_valid), .ser_data(ser_data), .ser_ready(ser_ready));

    initial forever #20 clock = ~clock;

    // Network stalls one cycle in three; cycle ceiling cuts a hang short
    always @(posedge clock)
    begin
        cyc <= cyc + 1;
        tx_ready <= (cyc % 3) != 0;
        if (cyc == 60000)
        begin
            failures++;
            final_report();
        end
    end

    // Collect released blocks as bytes and lengths
    always @(posedge clock)
        if (tx_valid && tx_ready)
        begin
            got_q.push_back(tx_data);
            run++;
            if (tx_last)
            begin
                len_q.push_back(run);
                run = 0;
            end
        end

    task automatic final_report();
        $display("checks_done=%0d failures=%0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk32(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e)
        begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        chk32({24'h0, g}, {24'h0, e});
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clock);
        addr <= a;
        wdata <= v;
        wr_en <= 1'b1;
        @(posedge clock);
        wr_en <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clock);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clock);
        rd_en <= 1'b0;
        @(negedge clock);
        d = rdata;
        chk32(d, e);
    endtask

    // Hand the whole source queue to the device in one go
    task automatic send_q();
        @(negedge clock);
        foreach (src_q[k]) dev.tx_q.push_back(src_q[k]);
        src_q.delete();
    endtask

    // Wait for the expected blocks, allow a late extra one, then compare
    task automatic expect_blocks();
        for (int i = 0; i < 4000 && len_q.size() < elen_q.size(); i++) @(posedge clock);
        repeat (40) @(posedge clock);
        @(negedge clock);
        chk32(len_q.size(), elen_q.size());
        foreach (elen_q[k]) if (k < len_q.size()) chk32(len_q[k], elen_q[k]);
        foreach (exp_q[k]) if (k < got_q.size()) chk8(got_q[k], exp_q[k]);
        got_q.delete();
        exp_q.delete();
        len_q.delete();
        elen_q.delete();
    endtask

    task automatic net_send(input logic [7:0] b);
        @(posedge clock);
        net_valid <= 1'b1;
        net_data <= b;
        for (int i = 0; i < 100; i++)
        begin
            @(negedge clock);
            if (net_ready === 1'b1) break;
        end
        @(posedge clock);
        net_valid <= 1'b0;
    endtask

    task automatic modem(input logic [1:0] e);
        @(negedge clock);
        chk8({6'h0, dtr, rts}, {6'h0, e});
    endtask

    initial
    begin
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        // Reset values, read-only status, unmapped place
        rd(OFS_LEN, 32'h0);
        rd(OFS_DELIM, 32'h0);
        rd(OFS_GAP, 32'h0);
        rd(OFS_MODEM, 32'h3);
        wr(OFS_STATUS, 32'hffffffff);
        wr(8'h20, 32'hffffffff);
        rd(OFS_STATUS, 32'h00100000);
        rd(8'h20, 32'h0);
        // Threshold of 3, then threshold off with no gap: remainder stays
        wr(OFS_LEN, 32'h3);
        for (int k = 0; k < 7; k++) src_q.push_back(8'(k));
        for (int k = 0; k < 6; k++) exp_q.push_back(8'(k));
        elen_q = '{3, 3};
        send_q();
        expect_blocks();
        wr(OFS_LEN, 32'h0);
        repeat (100) @(posedge clock);
        rd(OFS_STATUS, 32'h00100001);
        wr(OFS_GAP, 32'h1);
        exp_q = '{8'h06};
        elen_q = '{1};
        expect_blocks();
        // Every terminator option, then an option with the terminator off
        for (m = 0; m < 5; m++)
        begin
            wr(OFS_DELIM, (m < 4) ? (32'h0001000d | (32'(m) << F_MODE)) : 32'h0008000d);
            foreach (seq5[k])
            begin
                src_q.push_back(seq5[k]);
                if (!(m == 3 && k == 2)) exp_q.push_back(seq5[k]);
            end
            elen_q.push_back(first[m]);
            if (exp_q.size() > first[m]) elen_q.push_back(exp_q.size() - first[m]);
            send_q();
            expect_blocks();
        end
        // Two terminators must arrive as a pair
        wr(OFS_DELIM, 32'h00030a0d);
        rd(OFS_DELIM, 32'h00030a0d);
        src_q = '{8'h61, 8'h0d, 8'h62, 8'h0d, 8'h0a, 8'h63};
        exp_q = src_q;
        elen_q = '{5, 1};
        send_q();
        expect_blocks();
        // Buffer full with a terminator armed
        wr(OFS_DELIM, 32'h0001000d);
        for (int k = 0; k < 1030; k++) src_q.push_back(8'h41);
        exp_q = src_q;
        elen_q = '{1024, 6};
        send_q();
        expect_blocks();
        // Modem controls against link state; link moves only on a rising edge
        @(posedge clock);
        link_up <= 1'b0;
        modem(2'b11);
        wr(OFS_MODEM, 32'h7);
        modem(2'b00);
        @(posedge clock);
        link_up <= 1'b1;
        modem(2'b11);
        wr(OFS_MODEM, 32'h6);
        rd(OFS_MODEM, 32'h6);
        modem(2'b10);
        // Network bytes reach the slow serial side in order
        for (int k = 0; k < 8; k++) net_send(8'h10 + 8'(k));
        repeat (40) @(posedge clock);
        chk32(dev.got_q.size(), 32'h8);
        foreach (dev.got_q[k]) chk8(dev.got_q[k], 8'h10 + 8'(k));
        final_report();
    end
endmodule // test_srp_packetizer
